// File: core/feedback_scaling_pulse_output.v
// Feedback direction, scaling and quadrature pulse regeneration with an APB slave.
//
// Local design decisions: the APB slave port and the address map.
`include "fb_scaling_defs.vh"
module feedback_scaling_pulse_output (
  input wire clock,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire motor_step,
  input wire motor_dir,
  input wire ext_step,
  input wire ext_dir,
  input wire cmd_forward,
  output reg drive_reverse,
  output reg phase_a_output,
  output reg phase_b_output,
  output reg index_pulse_output,
  output reg motor_load_deviation_alarm,
  output reg overspeed_alarm
);
  // ==========================================
  // Pending settings, written by software, active only after restart.
  reg [31:0] basic_function_switch_zero;
  reg [31:0] application_switch_two;
  reg [31:0] application_switch_eighty_one;
  reg [31:0] external_periods_per_rotation;
  reg [31:0] output_edges_per_period;
  reg [31:0] dev_limit_reg;
  // Active copies.
  reg act_dir_reg;
  reg [3:0] act_ext_reg;
  reg act_out_dis_reg;
  reg [31:0] act_periods_reg;
  reg [31:0] act_edges_reg;
  reg [31:0] act_limit_reg;
  reg bad_cfg_reg;
  reg [2:0] load_step_reg;
  reg loading_reg;
  wire [31:0] store_rdata;
  reg [31:0] pos_reg;
  reg [31:0] motor_acc_reg;
  reg [31:0] ext_pos_reg;
  reg [31:0] motor_pos_reg;
  reg [1:0] quad_reg;
  reg [31:0] out_acc_reg;
  reg [15:0] win_cnt_reg;
  reg [7:0] win_edges_reg;
  reg [31:0] rev_edges_reg;
  wire wr = psel & penable & pwrite;
  // Read data are registered in the setup cycle so that they stand at the access edge.
  // A limitation: ce must be high in the setup cycle of a read.
  wire rd = psel & ~penable & ~pwrite;
  // ==========================================
  // Functions
  function is_legal_ext;
    input [3:0] code;
    begin
      is_legal_ext = (code == `EXT_OFF) || (code == `EXT_FWD) || (code == `EXT_REV);
    end
  endfunction
  function [31:0] abs_diff;
    input [31:0] x;
    input [31:0] y;
    begin
      abs_diff = x[31] == y[31] ? (x > y ? x - y : y - x) : x - y;
      if (abs_diff[31]) begin
        abs_diff = ~abs_diff + 32'h00000001;
      end
    end
  endfunction
  function map_known;
    input [11:0] a;
    begin
      map_known = (a <= `OFS_DEV_LIMIT) && (a[1:0] == 2'h0);
    end
  endfunction
  // ==========================================
  // APB slave: zero wait states, error on unmapped or misaligned address.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~map_known(paddr);
  always @(posedge clock) begin
    if (rst) begin
      basic_function_switch_zero <= 32'h00000000;
      application_switch_two <= 32'h00000000;
      application_switch_eighty_one <= 32'h00000000;
      external_periods_per_rotation <= `PERIODS_RESET;
      output_edges_per_period <= `EDGES_RESET;
      dev_limit_reg <= `DEV_LIMIT_RESET;
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (wr) begin
        if (paddr == `OFS_SWITCH_ZERO) begin
          basic_function_switch_zero <= pwdata;
        end else if (paddr == `OFS_SWITCH_TWO) begin
          application_switch_two <= pwdata;
        end else if (paddr == `OFS_SWITCH_EIGHTY_ONE) begin
          application_switch_eighty_one <= pwdata;
        end else if (paddr == `OFS_PERIODS) begin
          // Software supplies an integer; a fractional ratio would only disturb speed.
          external_periods_per_rotation <= pwdata;
        end else if (paddr == `OFS_EDGES) begin
          output_edges_per_period <= pwdata;
        end else if (paddr == `OFS_DEV_LIMIT) begin
          dev_limit_reg <= pwdata;
        end
      end
      if (rd) begin
        if (paddr == `OFS_SWITCH_ZERO) begin
          prdata <= basic_function_switch_zero;
        end else if (paddr == `OFS_SWITCH_TWO) begin
          prdata <= application_switch_two;
        end else if (paddr == `OFS_SWITCH_EIGHTY_ONE) begin
          prdata <= application_switch_eighty_one;
        end else if (paddr == `OFS_PERIODS) begin
          prdata <= external_periods_per_rotation;
        end else if (paddr == `OFS_EDGES) begin
          prdata <= output_edges_per_period;
        end else if (paddr == `OFS_STATUS) begin
          prdata <= {28'h0000000, ~act_out_dis_reg, bad_cfg_reg, overspeed_alarm,
                     motor_load_deviation_alarm};
        end else if (paddr == `OFS_POSITION) begin
          prdata <= pos_reg;
        end else if (paddr == `OFS_DEV_LIMIT) begin
          prdata <= dev_limit_reg;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end
  // ==========================================
  // Restart: settings copied through the shadow store one word per cycle, the deviation limit directly from dev_limit_reg.
  wire restart = wr && (paddr == `OFS_CONTROL) && pwdata[`CTRL_RESTART_BIT];
  wire alarm_clear = wr && (paddr == `OFS_CONTROL) && pwdata[`CTRL_CLEAR_BIT];
  reg [31:0] store_wdata;
  always @* begin
    case (load_step_reg)
      3'h0: store_wdata = basic_function_switch_zero;
      3'h1: store_wdata = application_switch_two;
      3'h2: store_wdata = application_switch_eighty_one;
      3'h3: store_wdata = external_periods_per_rotation;
      3'h4: store_wdata = output_edges_per_period;
      default: store_wdata = dev_limit_reg;
    endcase
  end
  shadow_store u_store (
    .clock(clock),
    .ce(ce),
    .we(loading_reg),
    .waddr(load_step_reg),
    .wdata(store_wdata),
    .raddr(load_step_reg - 3'h1),
    .rdata(store_rdata)
  );
  wire load_done = loading_reg && (load_step_reg == 3'h6);
  always @(posedge clock) begin
    if (rst) begin
      loading_reg <= 1'b1;
      load_step_reg <= 3'h0;
    end else if (ce) begin
      if (restart) begin
        loading_reg <= 1'b1;
        load_step_reg <= 3'h0;
      end else if (loading_reg) begin
        load_step_reg <= load_done ? 3'h0 : load_step_reg + 3'h1;
        loading_reg <= ~load_done;
      end
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      act_dir_reg <= 1'b0;
      act_ext_reg <= `EXT_OFF;
      act_out_dis_reg <= 1'b1;
      act_periods_reg <= `PERIODS_RESET;
      act_edges_reg <= `EDGES_RESET;
      act_limit_reg <= `DEV_LIMIT_RESET;
      bad_cfg_reg <= 1'b0;
    end else if (ce && loading_reg) begin
      case (load_step_reg)
        3'h2: act_dir_reg <= store_rdata[`DIR_BIT];
        3'h3: begin
          act_ext_reg <= is_legal_ext(store_rdata[`EXT_USE_LSB+3:`EXT_USE_LSB]) ?
                         store_rdata[`EXT_USE_LSB+3:`EXT_USE_LSB] : `EXT_OFF;
          bad_cfg_reg <= ~is_legal_ext(store_rdata[`EXT_USE_LSB+3:`EXT_USE_LSB]);
        end
        3'h4: act_out_dis_reg <= store_rdata[`OUT_USE_LSB];
        3'h5: act_periods_reg <= store_rdata;
        3'h6: begin
          act_edges_reg <= store_rdata;
          act_limit_reg <= dev_limit_reg;
        end
        default: ;
      endcase
    end
  end
  // ==========================================
  // Command direction.
  always @(posedge clock) begin
    if (rst) begin
      drive_reverse <= 1'b0;
    end else if (ce) begin
      drive_reverse <= act_dir_reg ? cmd_forward : ~cmd_forward;
    end
  end
  // ==========================================
  // Motor to load comparison, external scaled by periods per rotation over 2^16
  // motor counts; scaling is accumulated so no fraction is lost.
  wire ext_used = act_ext_reg != `EXT_OFF;
  wire ext_up = (act_ext_reg == `EXT_REV) ? ~ext_dir : ext_dir;
  always @(posedge clock) begin
    if (rst) begin
      motor_acc_reg <= 32'h00000000;
      ext_pos_reg <= 32'h00000000;
      motor_pos_reg <= 32'h00000000;
      motor_load_deviation_alarm <= 1'b0;
    end else if (ce) begin
      if (loading_reg) begin
        motor_acc_reg <= 32'h00000000;
        ext_pos_reg <= 32'h00000000;
        motor_pos_reg <= 32'h00000000;
      end else begin
        if (motor_step) begin
          motor_pos_reg <= motor_dir ? motor_pos_reg + act_periods_reg :
                           motor_pos_reg - act_periods_reg;
        end
        if (ext_step && ext_used) begin
          ext_pos_reg <= ext_up ? ext_pos_reg + 32'h00010000 : ext_pos_reg - 32'h00010000;
        end
      end
      if (ext_used && !loading_reg &&
          abs_diff(motor_pos_reg, ext_pos_reg) > act_limit_reg) begin
        motor_load_deviation_alarm <= 1'b1;
      end else if (alarm_clear) begin
        motor_load_deviation_alarm <= 1'b0;
      end
    end
  end
  // ==========================================
  // Pulse output: each motor step adds edges-per-period to an accumulator; one
  // output edge per 65536 units keeps the resolution exact.
  wire out_on = ~act_out_dis_reg & ~loading_reg;
  wire [31:0] acc_sum = out_acc_reg + act_edges_reg;
  wire emit = out_on && motor_step && (acc_sum >= 32'h00010000);
  wire rev_wrap = motor_dir ? (rev_edges_reg == act_edges_reg - 32'h00000001) :
                  (rev_edges_reg == 32'h00000000);
  // Gray order 00, 10, 11, 01 while counting up, so phase A leads for forward motion.
  wire [1:0] quad_next = motor_dir ? quad_reg + 2'h1 : quad_reg - 2'h1;
  always @(posedge clock) begin
    if (rst) begin
      out_acc_reg <= 32'h00000000;
      quad_reg <= 2'h0;
      phase_a_output <= 1'b0;
      phase_b_output <= 1'b0;
      index_pulse_output <= 1'b0;
      rev_edges_reg <= 32'h00000000;
      pos_reg <= 32'h00000000;
    end else if (ce) begin
      if (!out_on) begin
        out_acc_reg <= 32'h00000000;
        quad_reg <= 2'h0;
        phase_a_output <= 1'b0;
        phase_b_output <= 1'b0;
        index_pulse_output <= 1'b0;
      end else if (motor_step) begin
        out_acc_reg <= emit ? acc_sum - 32'h00010000 : acc_sum;
        if (emit) begin
          quad_reg <= quad_next;
          phase_a_output <= quad_next[1] ^ quad_next[0];
          phase_b_output <= quad_next[1];
          index_pulse_output <= rev_wrap;
          rev_edges_reg <= rev_wrap ? (motor_dir ? 32'h00000000 :
                           act_edges_reg - 32'h00000001) :
                           (motor_dir ? rev_edges_reg + 32'h00000001 :
                           rev_edges_reg - 32'h00000001);
          pos_reg <= motor_dir ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;
        end
      end
    end
  end
  // ==========================================
  // Overspeed: count output edges in a fixed window against the 6.4 Mpps bound.
  always @(posedge clock) begin
    if (rst) begin
      win_cnt_reg <= 16'h0000;
      win_edges_reg <= 8'h00;
      overspeed_alarm <= 1'b0;
    end else if (ce) begin
      if (win_cnt_reg == `RATE_WINDOW_CYCLES - 1) begin
        win_cnt_reg <= 16'h0000;
        win_edges_reg <= 8'h00;
      end else begin
        win_cnt_reg <= win_cnt_reg + 16'h0001;
        win_edges_reg <= (emit && win_edges_reg != 8'hFF) ? win_edges_reg + 8'h01 :
                         win_edges_reg;
      end
      if (win_edges_reg > `MAX_EDGES_PER_WINDOW) begin
        overspeed_alarm <= 1'b1;
      end else if (alarm_clear) begin
        overspeed_alarm <= 1'b0;
      end
    end
  end
endmodule

// File: core/fb_scaling_defs.vh
// Register map, field positions, reset values and timing counts of the feedback scaling block.
// Contract
// - Direction bit: 0 forward, 1 reversed command.
// - External usage 0 off, 1 forward, 3 reversed.
// - Divergent motor and load raise deviation alarm.
// - External periods per rotation, default 32768.
// - Output edges per period, default 20.
// - Edge rate over 6.4 Mpps raises overspeed.
// - Output usage 0 enables, 1 disables output.
// - Index transitions only with A or B edges; a reload or output disable clears it even when A and B stay low.
`ifndef FB_SCALING_DEFS_VH
`define FB_SCALING_DEFS_VH
// ==========================================
// Register offsets
`define OFS_SWITCH_ZERO 12'h000
`define OFS_SWITCH_TWO 12'h004
`define OFS_SWITCH_EIGHTY_ONE 12'h008
`define OFS_PERIODS 12'h00C
`define OFS_EDGES 12'h010
`define OFS_CONTROL 12'h014
`define OFS_STATUS 12'h018
`define OFS_POSITION 12'h01C
`define OFS_DEV_LIMIT 12'h020
// ==========================================
// Field positions
`define DIR_BIT 0
`define EXT_USE_LSB 12
`define OUT_USE_LSB 4
`define CTRL_RESTART_BIT 0
`define CTRL_CLEAR_BIT 1
`define STAT_DEV_BIT 0
`define STAT_OVS_BIT 1
`define STAT_BADCFG_BIT 2
`define STAT_OUTEN_BIT 3
// ==========================================
// Reset values and codes
`define EXT_OFF 4'h0
`define EXT_FWD 4'h1
`define EXT_REV 4'h3
`define PERIODS_RESET 32'h00008000
`define EDGES_RESET 32'h00000014
`define DEV_LIMIT_RESET 32'h00010000
// ==========================================
// Timing: 6.4 Mpps at 200 MHz is one edge per 31.25 cycles; a window of 2000
// cycles (10 us) may carry 64 edges at most.
`define CLOCK_MHZ 200
`define RATE_WINDOW_US 10
`define RATE_WINDOW_CYCLES (`CLOCK_MHZ * `RATE_WINDOW_US)
`define MAX_EDGES_PER_WINDOW 64
`endif

// File: core/shadow_store.v
// Small register memory holding the active (restarted) copies of the settings.
module shadow_store (
  input wire clock,
  input wire ce,
  input wire we,
  input wire [2:0] waddr,
  input wire [31:0] wdata,
  input wire [2:0] raddr,
  output reg [31:0] rdata
);
  reg [31:0] mem [0:7];
  always @(posedge clock) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// File: testbench/quad_counter.sv
// Upper controller model that counts quadrature edges into a position.
module quad_counter (
  input wire logic clock,
  input wire logic rst,
  input wire logic a,
  input wire logic b,
  output int count,
  output int jumps
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Decoder; a double step cannot be told apart, so it is counted as a fault.
  logic [1:0] prev;
  function automatic int phase(input logic [1:0] v);
    return v[0] ? (v[1] ? 2 : 3) : (v[1] ? 1 : 0);
  endfunction
  always @(posedge clock) begin
    prev <= {a, b};
    if (rst) begin
      count <= 0;
      jumps <= 0;
    end else begin
      case ((phase({a, b}) - phase(prev)) & 3)
        1: count <= count + 1;
        3: count <= count - 1;
        2: jumps <= jumps + 1;
        default: ;
      endcase
    end
  end
endmodule

// File: testbench/fsp_props.sv
// Concurrent checks on the ports of the feedback scaling block.
`include "fb_scaling_defs.vh"
module fsp_props (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire phase_a_output,
  input wire phase_b_output,
  input wire index_pulse_output,
  input wire motor_load_deviation_alarm,
  input wire overspeed_alarm
);
  // ==========
  // Properties.
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A control write may clear alarms, so stickiness is only claimed without one.
  wire ctl_wr = psel && penable && pwrite && paddr == `OFS_CONTROL;
  sequence access_s;
    psel && penable;
  endsequence
  sequence quiet_s;
    !phase_a_output && !phase_b_output && !index_pulse_output;
  endsequence
  ready_high_a: assert property (access_s |-> pready)
    else $error("pready low in access phase");
  err_access_a: assert property (pslverr |-> access_s)
    else $error("pslverr outside access phase");
  err_read_a: assert property (access_s ##0 (!pwrite && pslverr) |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  restart_quiet_a: assert property ($fell(rst) |-> quiet_s [*7])
    else $error("pulse output moved during restart load");
  quad_step_a: assert property ($changed(phase_a_output) |-> $stable(phase_b_output))
    else $error("both phases changed together");
  index_align_a: assert property ($changed(index_pulse_output) |->
    $changed(phase_a_output) || $changed(phase_b_output))
    else $error("index moved without a phase edge");
  dev_sticky_a: assert property (motor_load_deviation_alarm && !ctl_wr |=>
    motor_load_deviation_alarm) else $error("deviation alarm dropped");
  ovs_sticky_a: assert property (overspeed_alarm && !ctl_wr |=> overspeed_alarm)
    else $error("overspeed alarm dropped");
endmodule

// File: testbench/tb_top.sv
// Testbench driving the feedback scaling block over APB and counting its pulses.
`include "fb_scaling_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Stimulus, instances and tasks.
  logic clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic motor_step = 0, motor_dir = 1, ext_step = 0, ext_dir = 1, cmd_forward = 1;
  wire pready, pslverr, drive_reverse, phase_a_output, phase_b_output, index_pulse_output;
  wire motor_load_deviation_alarm, overspeed_alarm;
  wire [31:0] prdata;
  int num_errors = 0, cmp_count = 0, count, jumps;
  always #2.5 clock = ~clock;
  feedback_scaling_pulse_output u_feedback_scaling_pulse_output (.clock, .rst, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .motor_step, .motor_dir,
    .ext_step, .ext_dir, .cmd_forward, .drive_reverse, .phase_a_output, .phase_b_output,
    .index_pulse_output, .motor_load_deviation_alarm, .overspeed_alarm);
  quad_counter u_quad_counter (.clock, .rst, .a(phase_a_output), .b(phase_b_output), .count,
    .jumps);
  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    err = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge, so a following call never reassigns psel in the same time step.
    @(posedge clock);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic restart;
    xfer(1'h1, `OFS_CONTROL, 32'h00000001);
    repeat (10) @(posedge clock);
  endtask
  task automatic steps(input int n, input logic dir, input logic ext, input int gap);
    for (int i = 0; i < n; i++) begin
      motor_dir <= dir;
      motor_step <= 1'h1;
      ext_step <= ext;
      @(posedge clock);
      motor_step <= 1'h0;
      ext_step <= 1'h0;
      repeat (gap) @(posedge clock);
    end
    repeat (12) @(posedge clock);
  endtask
  task automatic t_regs;
    xfer(1'h0, `OFS_PERIODS, 32'h0);
    chk("periods", rd, `PERIODS_RESET);
    xfer(1'h0, `OFS_EDGES, 32'h0);
    chk("edges", rd, `EDGES_RESET);
    xfer(1'h0, `OFS_STATUS, 32'h0);
    chk("status", rd, 32'h00000008);
    xfer(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
  endtask
  task automatic t_dir;
    for (int d = 1; d >= 0; d--) begin
      xfer(1'h1, `OFS_SWITCH_ZERO, 32'(d));
      restart();
      for (int c = 0; c < 2; c++) begin
        cmd_forward <= c[0];
        repeat (3) @(posedge clock);
        chk("reverse", 32'(drive_reverse), 32'(d[0] ^ !c[0]));
      end
    end
  endtask
  task automatic t_motion;
    xfer(1'h1, `OFS_EDGES, 32'h00010000);
    restart();
    steps(20, 1'h1, 1'h0, 6);
    chk("count fwd", 32'(count), 32'h14);
    steps(20, 1'h0, 1'h0, 6);
    chk("count back", 32'(count), 32'h0);
    chk("jumps", 32'(jumps), 32'h0);
    // Stepping back across the revolution wrap emits the index with that edge.
    steps(1, 1'h0, 1'h0, 6);
    chk("index", 32'(index_pulse_output), 32'h1);
    steps(1, 1'h1, 1'h0, 6);
    chk("no overspeed", 32'(overspeed_alarm), 32'h0);
    // Any split of 140 edges over two windows leaves one above the limit.
    steps(140, 1'h1, 1'h0, 2);
    chk("overspeed", 32'(overspeed_alarm), 32'h1);
    chk("index low", 32'(index_pulse_output), 32'h0);
    repeat (2100) @(posedge clock);
    xfer(1'h1, `OFS_CONTROL, 32'h00000002);
    repeat (3) @(posedge clock);
    chk("cleared", 32'(overspeed_alarm), 32'h0);
  endtask
  task automatic t_off;
    xfer(1'h1, `OFS_SWITCH_EIGHTY_ONE, 32'h00000010);
    for (int c = 0; c < 5; c++) begin
      xfer(1'h1, `OFS_SWITCH_TWO, 32'(c) << 12);
      restart();
      xfer(1'h0, `OFS_STATUS, 32'h0);
      chk("ext code", rd & 32'hC, (c == 2 || c == 4) ? 32'h4 : 32'h0);
    end
    steps(8, 1'h1, 1'h0, 6);
    chk("disabled", 32'(count), 32'h8C);
    xfer(1'h0, `OFS_POSITION, 32'h0);
    chk("position", rd, 32'h0000008C);
  endtask
  task automatic t_dev;
    xfer(1'h1, `OFS_SWITCH_TWO, 32'h00001000);
    xfer(1'h1, `OFS_SWITCH_EIGHTY_ONE, 32'h0);
    xfer(1'h1, `OFS_PERIODS, 32'h00008000);
    restart();
    steps(2, 1'h1, 1'h1, 6);
    steps(2, 1'h1, 1'h0, 6);
    chk("in step", 32'(motor_load_deviation_alarm), 32'h0);
    steps(3, 1'h1, 1'h0, 6);
    chk("diverged", 32'(motor_load_deviation_alarm), 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    t_regs();
    t_dir();
    t_motion();
    t_off();
    t_dev();
    give_verdict();
  end
endmodule
bind feedback_scaling_pulse_output fsp_props u_fsp_props (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .phase_a_output, .phase_b_output,
  .index_pulse_output, .motor_load_deviation_alarm, .overspeed_alarm);
